// *** rtl/tmc_core.sv ***
// Overview of operation
// - Count equals comparator: interrupt, clear, pin change
// - Clock select field picks counter clock
// - External clock pin clocks or counts events
// - Comparators A and P each raise interrupt
// - External clock edge rising or falling
// - External clock pin triggers single pulse
// - Capture edge rising, falling or both
// - Periodic capture may use external clock pin
// - First standard instance lacks external clock
// - Compare match drives pin high, low, toggle
// - Output pin carries PWM waveform
// - High bytes direct, low bytes via buffer
// - Buffer loads only on high byte read or low compare write
// - Low compare write fills buffer only
// - High compare write also loads low byte
// - High read latches low byte into buffer
// - Low byte read returns the buffer
// - 16-bit counter, P compares top byte
// - Counter on rising edge clears counter
`timescale 1ns/10ps
`include "tmc_consts.svh"
module tmc_core
  import tmc_pkg::*;
#(
  parameter bit HAS_EXT_CLK = 1'b1
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Control bits
  input wire tmc_cfg_s i_cfg,
  // Byte access
  input wire tmc_req_s i_req,
  output logic [7:0] o_rdata,
  output logic o_rd_valid,
  // Internal clock sources
  input wire logic i_fh_tick,
  input wire logic i_sub_clk,
  // Pins
  input wire logic i_ext_clk_pin,
  input wire logic i_cap_pin,
  output logic o_timer_out,
  // Compare and capture events
  output logic o_irq_a,
  output logic o_irq_p
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [`TMC_PIN_N-1:0] pin_raw;
  logic [`TMC_PIN_N-1:0] sync1_ff;
  logic [`TMC_PIN_N-1:0] sync2_ff;
  logic [`TMC_PIN_N-1:0] sync3_ff;
  logic [`TMC_PIN_N-1:0] pin_rise;
  logic [`TMC_PIN_N-1:0] pin_fall;

  // Gather asynchronous inputs
  assign pin_raw = {i_sub_clk, i_cap_pin, i_ext_clk_pin};

  // Two-stage sync plus one delay stage for edges
  generate
    for (genvar gi = 0; gi < `TMC_PIN_N; gi++) begin : g_sync
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
          sync3_ff[gi] <= 1'b0;
        end else if (i_ce) begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
        end
      end
      // Edges from settled stages only
      assign pin_rise[gi] = sync2_ff[gi] & ~sync3_ff[gi];
      assign pin_fall[gi] = ~sync2_ff[gi] & sync3_ff[gi];
    end
  endgenerate

  // ----------------------------------------
  // Core state
  // ----------------------------------------
  logic on_ff;
  logic [`TMC_CNT_W-1:0] cnt_ff;
  logic [`TMC_CNT_W-1:0] a_ff;
  logic [`TMC_BYTE_W-1:0] p_ff;
  logic [`TMC_BYTE_W-1:0] buf_ff;
  logic [1:0] sysdiv_ff;
  logic [5:0] fhdiv_ff;
  logic lvl_ff;
  logic out_ff;
  tmc_sp_e sp_ff;
  logic irq_a_ff;
  logic irq_p_ff;
  logic [`TMC_BYTE_W-1:0] rdata_ff;
  logic rd_valid_ff;

  logic nxt_on;
  logic [`TMC_CNT_W-1:0] nxt_cnt;
  logic [`TMC_CNT_W-1:0] nxt_a;
  logic [`TMC_BYTE_W-1:0] nxt_p;
  logic [`TMC_BYTE_W-1:0] nxt_buf;
  logic [1:0] nxt_sysdiv;
  logic [5:0] nxt_fhdiv;
  logic nxt_lvl;
  logic nxt_out;
  tmc_sp_e nxt_sp;
  logic nxt_irq_a;
  logic nxt_irq_p;
  logic [`TMC_BYTE_W-1:0] nxt_rdata;
  logic nxt_rd_valid;

  // Derived events
  logic ext_rise, ext_fall, tick, on_rise, pulse_mode;
  logic run, step, hit_a, hit_p, trig, rd_go;
  logic cap_rise, cap_fall, cap_edge, cap_evt;

  // External pin absent on the first standard instance
  assign ext_rise = HAS_EXT_CLK & pin_rise[`TMC_PIN_EXT];
  assign ext_fall = HAS_EXT_CLK & pin_fall[`TMC_PIN_EXT];

  // Counter clock source selection
  always_comb begin
    case (i_cfg.clk_sel)
      `TMC_CK_SYS4: tick = (sysdiv_ff == `TMC_SYS4_LAST);
      `TMC_CK_SYS: tick = 1'b1;
      `TMC_CK_FH16: tick = i_fh_tick & (fhdiv_ff[3:0] == `TMC_FH16_LAST);
      `TMC_CK_FH64: tick = i_fh_tick & (fhdiv_ff == `TMC_FH64_LAST);
      `TMC_CK_SUB0: tick = pin_rise[`TMC_PIN_SUB];
      `TMC_CK_SUB1: tick = pin_rise[`TMC_PIN_SUB];
      `TMC_CK_EXT_R: tick = ext_rise;
      `TMC_CK_EXT_F: tick = ext_fall;
      default: tick = 1'b0;
    endcase
  end

  // Match, capture and trigger qualifiers
  assign on_rise = i_cfg.cnt_on & ~on_ff;
  assign pulse_mode = (i_cfg.mode == TMC_MODE_PWM) & i_cfg.single;
  assign run = i_cfg.cnt_on & ~i_cfg.pause & (~pulse_mode | (sp_ff == TMC_SP_RUN));
  assign step = run & tick;
  assign hit_a = step & (cnt_ff == a_ff) & (i_cfg.mode != TMC_MODE_CAP);
  assign hit_p = step & (cnt_ff == {p_ff, `TMC_P_LOW});
  assign cap_rise = i_cfg.cap_src ? ext_rise : pin_rise[`TMC_PIN_CAP];
  assign cap_fall = i_cfg.cap_src ? ext_fall : pin_fall[`TMC_PIN_CAP];
  assign trig = pulse_mode & i_cfg.cnt_on & ext_rise & (sp_ff == TMC_SP_IDLE);
  assign rd_go = i_req.rd & ~i_req.wr;

  // Capture edge choice
  always_comb begin
    case (i_cfg.pin_func)
      `TMC_PF_00: cap_edge = cap_rise;
      `TMC_PF_01: cap_edge = cap_fall;
      `TMC_PF_10: cap_edge = cap_rise | cap_fall;
      default: cap_edge = 1'b0;
    endcase
  end
  assign cap_evt = (i_cfg.mode == TMC_MODE_CAP) & i_cfg.cnt_on & cap_edge;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_on = i_cfg.cnt_on;
    nxt_cnt = cnt_ff;
    nxt_a = a_ff;
    nxt_p = p_ff;
    nxt_buf = buf_ff;
    nxt_sysdiv = sysdiv_ff + 2'h1;
    nxt_fhdiv = i_fh_tick ? fhdiv_ff + 6'h01 : fhdiv_ff;
    nxt_lvl = lvl_ff;
    nxt_sp = sp_ff;
    nxt_irq_a = hit_a | cap_evt;
    nxt_irq_p = hit_p;
    nxt_rdata = rdata_ff;
    nxt_rd_valid = rd_go;
    // Counter and output pin
    if (on_rise) begin
      nxt_cnt = `TMC_CNT_RST;
      nxt_lvl = i_cfg.out_init;
      nxt_sp = TMC_SP_IDLE;
    end else begin
      if (step) begin
        if ((hit_a & (i_cfg.cclr | pulse_mode)) | (hit_p & ~i_cfg.cclr)) begin
          nxt_cnt = `TMC_CNT_RST;
        end else begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end
      case (i_cfg.mode)
        TMC_MODE_CMP: begin
          if (hit_a) begin
            case (i_cfg.pin_func)
              `TMC_PF_01: nxt_lvl = 1'b0;
              `TMC_PF_10: nxt_lvl = 1'b1;
              `TMC_PF_11: nxt_lvl = ~lvl_ff;
              default: nxt_lvl = lvl_ff;
            endcase
          end
        end
        TMC_MODE_PWM: begin
          if (pulse_mode) begin
            case (sp_ff)
              TMC_SP_IDLE: begin
                if (trig) begin
                  nxt_sp = TMC_SP_RUN;
                  nxt_lvl = 1'b1;
                end
              end
              TMC_SP_RUN: begin
                if (hit_a) begin
                  nxt_sp = TMC_SP_IDLE;
                  nxt_lvl = 1'b0;
                end
              end
              default: nxt_sp = TMC_SP_IDLE;
            endcase
          end else if (step) begin
            nxt_lvl = (nxt_cnt < a_ff);
          end
        end
        default: nxt_lvl = lvl_ff;
      endcase
    end
    // Byte access through the shared buffer
    if (i_req.wr) begin
      if (i_req.sel == TMC_SEL_A_L) begin
        nxt_buf = i_req.wdata;
      end else if (i_req.sel == TMC_SEL_A_H) begin
        nxt_a = {i_req.wdata, buf_ff};
      end else if (i_req.sel == TMC_SEL_P) begin
        nxt_p = i_req.wdata;
      end
    end else if (i_req.rd) begin
      if (i_req.sel == TMC_SEL_CNT_H) begin
        nxt_rdata = cnt_ff[15:8];
        nxt_buf = cnt_ff[7:0];
      end else if (i_req.sel == TMC_SEL_A_H) begin
        nxt_rdata = a_ff[15:8];
        nxt_buf = a_ff[7:0];
      end else if (i_req.sel == TMC_SEL_P) begin
        nxt_rdata = p_ff;
      end else begin
        nxt_rdata = buf_ff;
      end
    end
    // Capture wins over a software write of the same cycle
    if (cap_evt) begin
      nxt_a = cnt_ff;
    end
    nxt_out = nxt_lvl ^ i_cfg.pol;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      on_ff <= 1'b0;
      cnt_ff <= `TMC_CNT_RST;
      a_ff <= `TMC_CNT_RST;
      p_ff <= `TMC_BYTE_RST;
      buf_ff <= `TMC_BYTE_RST;
      sysdiv_ff <= 2'h0;
      fhdiv_ff <= 6'h00;
      lvl_ff <= 1'b0;
      out_ff <= 1'b0;
      sp_ff <= TMC_SP_IDLE;
      irq_a_ff <= 1'b0;
      irq_p_ff <= 1'b0;
      rdata_ff <= `TMC_BYTE_RST;
      rd_valid_ff <= 1'b0;
    end else if (i_ce) begin
      on_ff <= nxt_on;
      cnt_ff <= nxt_cnt;
      a_ff <= nxt_a;
      p_ff <= nxt_p;
      buf_ff <= nxt_buf;
      sysdiv_ff <= nxt_sysdiv;
      fhdiv_ff <= nxt_fhdiv;
      lvl_ff <= nxt_lvl;
      out_ff <= nxt_out;
      sp_ff <= nxt_sp;
      irq_a_ff <= nxt_irq_a;
      irq_p_ff <= nxt_irq_p;
      rdata_ff <= nxt_rdata;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata = rdata_ff;
  assign o_rd_valid = rd_valid_ff;
  assign o_timer_out = out_ff;
  assign o_irq_a = irq_a_ff;
  assign o_irq_p = irq_p_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  // Settled external clock rise on an instance that has the external clock pin
  sequence ext_rise_s;
    i_ce && HAS_EXT_CLK && $rose(sync2_ff[`TMC_PIN_EXT]);
  endsequence

  // Comparator A hit while the clock enable is high
  sequence hit_a_s;
    i_ce && hit_a;
  endsequence

  ext_edge_tick_a: assert property (
    ext_rise_s and (i_cfg.clk_sel == `TMC_CK_EXT_R) |-> tick)
    else $error("external rising edge did not tick counter");
  match_a_irq_a: assert property (
    hit_a_s |=> o_irq_a)
    else $error("comparator A match gave no interrupt");
  match_p_irq_a: assert property (
    i_ce && step && (cnt_ff == {p_ff, `TMC_P_LOW}) |=> o_irq_p)
    else $error("comparator P match gave no interrupt");
  match_clear_a: assert property (
    hit_a_s and (i_cfg.cclr && !on_rise) |=> (cnt_ff == `TMC_CNT_RST))
    else $error("counter not cleared by comparator A match");
  on_rise_clear_a: assert property (
    i_ce && i_cfg.cnt_on && !on_ff |=> (cnt_ff == `TMC_CNT_RST))
    else $error("counter not cleared when switched on");
  low_write_buf_a: assert property (
    i_ce && i_req.wr && (i_req.sel == TMC_SEL_A_L) && !cap_evt
    |=> (buf_ff == $past(i_req.wdata)) && (a_ff == $past(a_ff)))
    else $error("low byte write touched compare value");
  high_write_load_a: assert property (
    i_ce && i_req.wr && (i_req.sel == TMC_SEL_A_H) && !cap_evt
    |=> (a_ff == {$past(i_req.wdata), $past(buf_ff)}))
    else $error("high byte write did not load buffer into low byte");
  high_read_latch_a: assert property (
    i_ce && rd_go && (i_req.sel == TMC_SEL_CNT_H)
    |=> o_rd_valid && (o_rdata == $past(cnt_ff[15:8])) && (buf_ff == $past(cnt_ff[7:0])))
    else $error("counter high read did not latch low byte");
  low_read_buf_a: assert property (
    i_ce && rd_go && (i_req.sel == TMC_SEL_A_L) |=> (o_rdata == $past(buf_ff)))
    else $error("low byte read did not return buffer");
  cmp_toggle_a: assert property (
    hit_a_s and (i_cfg.mode == TMC_MODE_CMP && i_cfg.pin_func == `TMC_PF_11 && !on_rise)
    |=> (lvl_ff != $past(lvl_ff)))
    else $error("compare toggle did not change output");
  capture_load_a: assert property (
    i_ce && cap_evt |=> (a_ff == $past(cnt_ff)) && o_irq_a)
    else $error("capture did not load counter value");

endmodule

// *** rtl/tmc_consts.svh ***
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define TMC_CNT_W 16
`define TMC_BYTE_W 8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TMC_CNT_RST 16'h0000
`define TMC_BYTE_RST 8'h00

// ----------------------------------------
// Clock select field codes
// ----------------------------------------
`define TMC_CK_SYS4 3'h0
`define TMC_CK_SYS 3'h1
`define TMC_CK_FH16 3'h2
`define TMC_CK_FH64 3'h3
`define TMC_CK_SUB0 3'h4
`define TMC_CK_SUB1 3'h5
`define TMC_CK_EXT_R 3'h6
`define TMC_CK_EXT_F 3'h7

// ----------------------------------------
// Prescaler terminal counts
// ----------------------------------------
`define TMC_SYS4_LAST 2'h3
`define TMC_FH16_LAST 4'hf
`define TMC_FH64_LAST 6'h3f

// ----------------------------------------
// Pin function codes (capture edge / compare action)
// ----------------------------------------
`define TMC_PF_00 2'h0
`define TMC_PF_01 2'h1
`define TMC_PF_10 2'h2
`define TMC_PF_11 2'h3

// ----------------------------------------
// Synchroniser lanes
// ----------------------------------------
`define TMC_PIN_N 3
`define TMC_PIN_EXT 0
`define TMC_PIN_CAP 1
`define TMC_PIN_SUB 2

// ----------------------------------------
// Compare P low byte of the full count
// ----------------------------------------
`define TMC_P_LOW 8'hff

`endif

// *** rtl/tmc_pkg.sv ***
package tmc_pkg;
  // Operating modes
  typedef enum logic [1:0] {
    TMC_MODE_CMP = 2'h0,
    TMC_MODE_CAP = 2'h1,
    TMC_MODE_PWM = 2'h2,
    TMC_MODE_TMR = 2'h3
  } tmc_mode_e;
  // Byte access selects
  typedef enum logic [2:0] {
    TMC_SEL_CNT_L = 3'h0,
    TMC_SEL_CNT_H = 3'h1,
    TMC_SEL_A_L = 3'h2,
    TMC_SEL_A_H = 3'h3,
    TMC_SEL_P = 3'h4
  } tmc_sel_e;
  // Single pulse states, one-hot
  typedef enum logic [1:0] {
    TMC_SP_IDLE = 2'b01,
    TMC_SP_RUN = 2'b10
  } tmc_sp_e;
  // Control bits
  typedef struct packed {
    logic cnt_on;
    logic pause;
    logic [2:0] clk_sel;
    tmc_mode_e mode;
    logic [1:0] pin_func;
    logic out_init;
    logic pol;
    logic cclr;
    logic single;
    logic cap_src;
  } tmc_cfg_s;
  // Byte access request
  typedef struct packed {
    logic rd;
    logic wr;
    tmc_sel_e sel;
    logic [7:0] wdata;
  } tmc_req_s;
endpackage

// *** sim/tmc_pin_model.sv ***
`timescale 1ns/10ps
// ------------
// Pin driver
// ------------
module tmc_pin_model (
  // Clock
  input wire logic i_clk,
  // Pins
  output logic o_ext,
  output logic o_cap,
  output logic o_sub
);
  // Idle pins rest low
  initial begin
    o_ext = 1'b0;
    o_cap = 1'b0;
  end
  // Sub clock, 80 ns, off the rising clock edges
  initial begin
    o_sub = 1'b0;
    forever #40 o_sub = ~o_sub;
  end
  // Pulses long enough to clear the synchroniser
  task automatic pulse(input bit cap, input int n);
    repeat (n) begin
      #2;
      if (cap) o_cap = 1'b1; // Routed pin
      else o_ext = 1'b1; // Routed pin
      repeat (4) @(posedge i_clk);
      #2;
      if (cap) o_cap = 1'b0;
      else o_ext = 1'b0;
      repeat (4) @(posedge i_clk);
    end
  endtask
endmodule

// *** sim/tb_timer_module_common_core.sv ***
`timescale 1ns/10ps
module tb_timer_module_common_core;
  import tmc_pkg::*;
  // ------------
  // Stimulus
  // ------------
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_ce = 1'b1;
  logic i_fh_tick = 1'b0;
  tmc_cfg_s cfg = '0;
  tmc_req_s req = '0;
  logic [7:0] rdata;
  logic [7:0] rdata0;
  logic rd_valid, tout, irq_a, irq_p, ext, cap, sub;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int irqs = 0;
  int his = 0;
  int pt[6] = '{12, 3, 96, 384, 24, 24};
  int ce[4] = '{1, 1, 2, 0};

  // Clock and high-speed tick every other cycle
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) i_fh_tick <= ~i_fh_tick;

  // Devices under test and far-side pins
  tmc_core #(.HAS_EXT_CLK(1'b1)) DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_cfg(cfg), .i_req(req), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .i_fh_tick(i_fh_tick), .i_sub_clk(sub), .i_ext_clk_pin(ext), .i_cap_pin(cap),
    .o_timer_out(tout), .o_irq_a(irq_a), .o_irq_p(irq_p));
  tmc_core #(.HAS_EXT_CLK(1'b0)) DUT0 (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_cfg(cfg), .i_req(req), .o_rdata(rdata0), .o_rd_valid(),
    .i_fh_tick(i_fh_tick), .i_sub_clk(sub), .i_ext_clk_pin(ext), .i_cap_pin(cap),
    .o_timer_out(), .o_irq_a(), .o_irq_p());
  tmc_pin_model PM (.i_clk(i_clk), .o_ext(ext), .o_cap(cap), .o_sub(sub));

  // Cycle ceiling, event and high-level counts
  always @(posedge i_clk) begin
    cycles++;
    if (irq_a === 1'b1) irqs++;
    if (tout === 1'b1) his++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  // ------------
  // Tasks
  // ------------
  task summarize;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task acc(input logic w, input tmc_sel_e s, input logic [7:0] d);
    @(posedge i_clk);
    req <= '{rd: ~w, wr: w, sel: s, wdata: d};
    @(posedge i_clk);
    req <= '0;
    #1;
  endtask

  task rd(input tmc_sel_e s, input logic [7:0] e);
    acc(1'b0, s, 8'h00);
    chk({7'h00, rd_valid, rdata}, {8'h01, e});
  endtask

  // New settings, then counter on from low to high
  task go(input tmc_cfg_s c);
    c.cnt_on = 1'b0;
    @(posedge i_clk);
    cfg <= c;
    @(posedge i_clk);
    cfg.cnt_on <= 1'b1;
  endtask

  task waitirq(input bit p, output int n);
    n = 0;
    while (n < 1000 && (p ? irq_p : irq_a) !== 1'b1) begin
      @(posedge i_clk);
      #1;
      n++;
    end
  endtask

  // Spacing of two matches, and pin toggle or hold on A
  task per(input bit p, input bit tg, input int exp);
    int n;
    logic o;
    waitirq(p, n);
    o = tout;
    @(posedge i_clk);
    #1;
    waitirq(p, n);
    chk(16'(n + 1), 16'(exp));
    if (!p) chk({15'h0, tout}, {15'h0, tg ? ~o : o});
  endtask

  // ------------
  // Tests
  // ------------
  initial begin
    tmc_cfg_s c;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    acc(1'b1, TMC_SEL_A_L, 8'h34);
    rd(TMC_SEL_A_H, 8'h00);
    rd(TMC_SEL_A_L, 8'h00);
    acc(1'b1, TMC_SEL_A_L, 8'h34);
    rd(TMC_SEL_CNT_L, 8'h34);
    acc(1'b1, TMC_SEL_A_H, 8'h12);
    rd(TMC_SEL_A_H, 8'h12);
    rd(TMC_SEL_A_L, 8'h34);
    // Write while frozen by the clock enable is lost
    @(posedge i_clk);
    i_ce <= 1'b0;
    acc(1'b1, TMC_SEL_A_H, 8'h77);
    @(posedge i_clk);
    i_ce <= 1'b1;
    rd(TMC_SEL_A_H, 8'h12);
    acc(1'b1, TMC_SEL_CNT_H, 8'h55);
    rd(TMC_SEL_CNT_H, 8'h00);
    $display("test byte access done");
    acc(1'b1, TMC_SEL_A_L, 8'h02);
    acc(1'b1, TMC_SEL_A_H, 8'h00);
    c = '0;
    c.cclr = 1'b1;
    c.pin_func = 2'h3;
    for (int s = 0; s < 6; s++) begin
      c.clk_sel = 3'(s);
      go(c);
      per(1'b0, 1'b1, pt[s]);
    end
    c.clk_sel = 3'h1;
    for (int f = 1; f < 3; f++) begin
      c.pin_func = 2'(f);
      c.out_init = (f == 1);
      go(c);
      per(1'b0, 1'b0, 3);
      chk({15'h0, tout}, 16'(f - 1));
    end
    $display("test compare done");
    c.pin_func = 2'h0;
    c.mode = TMC_MODE_PWM;
    go(c);
    repeat (6) @(posedge i_clk);
    #1;
    his = 0;
    repeat (30) @(posedge i_clk);
    #1;
    chk(16'(his), 16'd20);
    c.single = 1'b1;
    go(c);
    repeat (6) @(posedge i_clk);
    #1;
    his = 0;
    PM.pulse(1'b0, 1);
    repeat (10) @(posedge i_clk);
    #1;
    chk(16'(his), 16'd3);
    chk({15'h0, tout}, 16'h0000);
    $display("test pwm done");
    c.single = 1'b0;
    c.cclr = 1'b0;
    c.mode = TMC_MODE_TMR;
    acc(1'b1, TMC_SEL_P, 8'h00);
    go(c);
    per(1'b1, 1'b0, 256);
    acc(1'b1, TMC_SEL_A_L, 8'hff);
    acc(1'b1, TMC_SEL_A_H, 8'hff);
    for (int s = 6; s < 8; s++) begin
      c.clk_sel = 3'(s);
      go(c);
      PM.pulse(1'b0, 5);
      rd(TMC_SEL_CNT_H, 8'h00);
      rd(TMC_SEL_CNT_L, 8'h05);
      chk(16'(rdata0), 16'h0000);
    end
    $display("test external clock done");
    c.clk_sel = 3'h1;
    c.mode = TMC_MODE_CAP;
    for (int f = 0; f < 5; f++) begin
      c.pin_func = (f == 4) ? 2'h2 : 2'(f);
      c.cap_src = (f == 4);
      go(c);
      irqs = 0;
      PM.pulse(f == 4 ? 1'b0 : 1'b1, 1);
      repeat (2) @(posedge i_clk);
      #1;
      chk(16'(irqs), f == 4 ? 16'd2 : 16'(ce[f]));
    end
    $display("test capture done");
    summarize();
  end
endmodule
